// >>> fpuex_pkg.sv
package fpuex_pkg;
  // exception class bit positions
  localparam int EXC_INVALID = 0;
  localparam int EXC_ZERODIV = 1;
  localparam int EXC_DENORM = 2;
  localparam int EXC_OVERFLOW = 3;
  localparam int EXC_UNDERFLOW = 4;
  localparam int EXC_INEXACT = 5;
  localparam int EXC_CLASSES = 6;
  // reset values
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [5:0] MASKS_RESET = 6'h3F;
  localparam logic [1:0] ROUND_RESET = 2'h0;
  // extra cycles spent on a masked fix-up
  localparam int FIXUP_NS = 20;
  localparam int CLK_NS = 10;
  localparam int FIXUP_CYCLES = (FIXUP_NS + CLK_NS - 1) / CLK_NS;

  typedef logic [EXC_CLASSES-1:0] fpuex_vec_t;

  typedef enum logic [1:0] {
    RND_NEAREST,
    RND_DOWN,
    RND_UP,
    RND_TOWARD_ZERO
  } fpuex_round_e;

  // kinds of fix-up the datapath should apply
  typedef enum logic [2:0] {
    FIX_NONE,
    FIX_QNAN,
    FIX_INFINITY,
    FIX_DENORMAL,
    FIX_ZERO,
    FIX_ROUNDED
  } fpuex_fix_e;

  // one instruction's exception report from the datapath
  typedef struct packed {
    logic valid;
    fpuex_vec_t exc;
    logic below_min_denorm;
    logic nowait;
  } fpuex_report_s;

  // software operations that touch the flags, masks and rounding
  typedef struct packed {
    logic clear_exceptions_op;
    logic fpu_reinit_op;
    logic state_save_op;
    logic restore_op;
    fpuex_vec_t restore_flags;
    logic mask_write;
    fpuex_vec_t mask_value;
    logic [1:0] round_value;
  } fpuex_ctl_s;
endpackage

// >>> fpuex_fixup_sel.sv
module fpuex_fixup_sel
  import fpuex_pkg::*;
(
  // exceptions seen in one instruction
  input wire fpuex_pkg::fpuex_vec_t exc,
  input wire logic below_min_denorm,
  input wire fpuex_pkg::fpuex_vec_t masks,
  // chosen default result
  output fpuex_pkg::fpuex_fix_e fix
);
  always_comb begin
    fix = FIX_NONE;
    // priority: invalid, divide-by-zero, overflow, underflow, inexact; a masked denormal alone selects no fix-up
    if (exc[EXC_INVALID] && masks[EXC_INVALID]) begin
      fix = FIX_QNAN;
    end else if (exc[EXC_ZERODIV] && masks[EXC_ZERODIV]) begin
      fix = FIX_INFINITY;
    end else if (exc[EXC_OVERFLOW] && masks[EXC_OVERFLOW]) begin
      fix = FIX_INFINITY;
    end else if (exc[EXC_UNDERFLOW] && masks[EXC_UNDERFLOW]) begin
      fix = below_min_denorm ? FIX_ZERO : FIX_DENORMAL;
    end else if (exc[EXC_INEXACT] && masks[EXC_INEXACT]) begin
      fix = FIX_ROUNDED;
    end
  end
endmodule

// >>> fpuex_unit.sv
// Functional notes
// - six sticky flags and six mask bits, one per exception class
// - mask bit 1 means apply default fix-up and continue
// - masked exception gives no external signal, only a longer instruction
// - masked flag set keeps no record of instruction or time
// - several flags may be raised by one instruction
// - masked underflow yields denormal, or zero below smallest denormal
// - masked inexact uses one of four selected rounding modes
// - masked divide-by-zero yields infinity; one over infinity yields zero
// - unmasked exception stops instruction and branches to handler
// - flags sticky; cleared only by clear, reinit, save or restore
// - freeze before next wait or float op unless ignore or no-wait
// - error output asserted at detection or at next wait/float op
// - frozen core stays frozen until an enabled interrupt, the ignore input or no pending error
// - native mode off and ignore input active: disregard and continue
// - unmasked exception reported on a dedicated error status line
// - compatibility mode selected by native error mode bit at 0
// - classes: invalid, divide-by-zero, denormal, overflow, underflow, inexact
module fpuex_unit
  import fpuex_pkg::*;
#(
  parameter int FIXUP_CNT = FIXUP_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // datapath report and software operations
  input wire fpuex_pkg::fpuex_report_s report,
  input wire fpuex_pkg::fpuex_ctl_s ctl,
  // next instruction is a wait or float op asking to start
  input wire logic wait_or_float_req,
  input wire logic next_is_nowait,
  // system pins and mode
  input wire logic native_error_mode_bit,
  input wire logic ignore_numeric_error_in,
  input wire logic maskable_interrupt_request_in,
  // status
  output fpuex_pkg::fpuex_vec_t status_flags,
  output fpuex_pkg::fpuex_vec_t control_masks,
  output fpuex_pkg::fpuex_round_e round_mode,
  output fpuex_pkg::fpuex_fix_e fixup_kind,
  output logic fixup_stall,
  output logic instr_abort,
  output logic handler_branch,
  output logic core_frozen,
  output logic fpu_error_out,
  output logic coproc_error_status
);
  import fpuex_pkg::*;

  // two-flop synchronisers for the pins
  logic [1:0] ign_sync_q, ign_sync_d;
  logic [1:0] maskable_interrupt_request_in_sync_q, maskable_interrupt_request_in_sync_d;
  logic ign_s, maskable_interrupt_request_in_s;

  fpuex_vec_t flags_q, flags_d;
  fpuex_vec_t masks_q, masks_d;
  fpuex_round_e round_q, round_d;
  fpuex_fix_e fix_q, fix_d;
  fpuex_fix_e fix_sel;
  logic [7:0] stall_cnt_q, stall_cnt_d;
  logic abort_q, abort_d;
  logic branch_q, branch_d;
  logic fpu_error_out_q, fpu_error_out_d;
  logic cerr_q, cerr_d;
  logic stall_q, stall_d;
  logic frozen_q, frozen_d;
  logic pending;
  logic compat_mode;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FROZEN,
    ST_BRANCH
  } fpuex_state_e;
  fpuex_state_e st_q, st_d;

  fpuex_fixup_sel u_fixup_sel (
    .exc(report.exc),
    .below_min_denorm(report.below_min_denorm),
    .masks(masks_q),
    .fix(fix_sel)
  );

  assign ign_s = ign_sync_q[1];
  assign maskable_interrupt_request_in_s = maskable_interrupt_request_in_sync_q[1];
  assign compat_mode = !native_error_mode_bit;
  assign pending = |(flags_q & ~masks_q);

  always_comb begin
    ign_sync_d = {ign_sync_q[0], ignore_numeric_error_in};
    maskable_interrupt_request_in_sync_d = {maskable_interrupt_request_in_sync_q[0], maskable_interrupt_request_in};
  end

  // flags, masks and rounding
  always_comb begin
    flags_d = flags_q;
    masks_d = masks_q;
    round_d = round_q;
    // software clears first so a same-cycle exception still lands
    if (ctl.clear_exceptions_op || ctl.fpu_reinit_op || ctl.state_save_op) begin
      flags_d = '0;
    end
    if (ctl.restore_op) begin
      flags_d = ctl.restore_flags;
    end
    if (ctl.fpu_reinit_op || ctl.state_save_op) begin
      masks_d = MASKS_RESET;
      round_d = fpuex_round_e'(ROUND_RESET);
    end else if (ctl.mask_write) begin
      masks_d = ctl.mask_value;
      round_d = fpuex_round_e'(ctl.round_value);
    end
    if (report.valid) begin
      // only the class bits are kept, never address or time
      flags_d = flags_d | report.exc;
    end
  end

  // masked fix-up and unmasked abort
  always_comb begin
    fix_d = fix_q;
    stall_cnt_d = (stall_cnt_q != 8'h00) ? stall_cnt_q - 8'h01 : 8'h00;
    abort_d = 1'b0;
    if (report.valid) begin
      fix_d = fix_sel;
      if (|(report.exc & masks_q)) begin
        // masked work costs time only; nothing leaves the block
        stall_cnt_d = 8'(FIXUP_CNT);
      end
      if (|(report.exc & ~masks_q)) begin
        abort_d = 1'b1;
      end
    end
    // registered so the stall pin never glitches on counter decode
    stall_d = (stall_cnt_d != 8'h00);
  end

  // freeze / branch control
  always_comb begin
    st_d = st_q;
    branch_d = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (pending && wait_or_float_req && !next_is_nowait) begin
          if (compat_mode && ign_s) begin
            st_d = ST_RUN;
          end else if (compat_mode) begin
            st_d = ST_FROZEN;
          end else begin
            st_d = ST_BRANCH;
          end
        end
      end
      ST_FROZEN: begin
        // any interrupt releases; so does ignore or no pending error, else we wait here
        if (maskable_interrupt_request_in_s) begin
          st_d = ST_RUN;
          branch_d = 1'b1;
        end else if (!pending || ign_s) begin
          st_d = ST_RUN;
        end
      end
      ST_BRANCH: begin
        branch_d = 1'b1;
        st_d = ST_RUN;
      end
      default: st_d = ST_RUN;
    endcase
    frozen_d = (st_d == ST_FROZEN);
  end

  // error reporting: fpu_error_out immediate on detection, held while pending, compatibility mode only; status line tracks pending
  always_comb begin
    fpu_error_out_d = compat_mode && (pending ||
      (report.valid && |(report.exc & ~masks_q)));
    cerr_d = pending;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ign_sync_q <= '0;
      maskable_interrupt_request_in_sync_q <= '0;
      flags_q <= FLAGS_RESET;
      masks_q <= MASKS_RESET;
      round_q <= RND_NEAREST;
      fix_q <= FIX_NONE;
      stall_cnt_q <= 8'h00;
      abort_q <= 1'b0;
      branch_q <= 1'b0;
      fpu_error_out_q <= 1'b0;
      cerr_q <= 1'b0;
      st_q <= ST_RUN;
      stall_q <= 1'b0;
      frozen_q <= 1'b0;
    end else begin
      ign_sync_q <= ign_sync_d;
      maskable_interrupt_request_in_sync_q <= maskable_interrupt_request_in_sync_d;
      flags_q <= flags_d;
      masks_q <= masks_d;
      round_q <= round_d;
      fix_q <= fix_d;
      stall_cnt_q <= stall_cnt_d;
      abort_q <= abort_d;
      branch_q <= branch_d;
      fpu_error_out_q <= fpu_error_out_d;
      cerr_q <= cerr_d;
      st_q <= st_d;
      stall_q <= stall_d;
      frozen_q <= frozen_d;
    end
  end

  assign status_flags = flags_q;
  assign control_masks = masks_q;
  assign round_mode = round_q;
  assign fixup_kind = fix_q;
  assign fixup_stall = stall_q;
  assign instr_abort = abort_q;
  assign handler_branch = branch_q;
  assign core_frozen = frozen_q;
  assign fpu_error_out = fpu_error_out_q;
  assign coproc_error_status = cerr_q;
endmodule

// >>> fpuex_assertions.sv
module fpuex_checker
  import fpuex_pkg::*;
(
  // clock, reset, inputs
  input wire logic ref_clk,
  input wire logic resetn,
  input wire fpuex_pkg::fpuex_report_s report,
  input wire fpuex_pkg::fpuex_ctl_s ctl,
  input wire logic wait_or_float_req,
  input wire logic next_is_nowait,
  input wire logic native_error_mode_bit,
  // outputs
  input wire fpuex_pkg::fpuex_vec_t status_flags,
  input wire fpuex_pkg::fpuex_vec_t control_masks,
  input wire logic fixup_stall,
  input wire logic instr_abort,
  input wire logic core_frozen,
  input wire logic fpu_error_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic unm;
  logic ops;
  logic nw;
  assign unm = report.valid && |(report.exc & ~control_masks);
  assign ops = ctl.clear_exceptions_op | ctl.fpu_reinit_op | ctl.state_save_op | ctl.restore_op;
  assign nw = wait_or_float_req && next_is_nowait && !core_frozen;
  AST_FLAG_SET: assert property (report.valid |=> &(status_flags | ~$past(report.exc)))
    else $error("flag not set");
  AST_ABORT: assert property (unm |=> instr_abort)
    else $error("no abort");
  AST_QUIET: assert property (report.valid && !unm |=> !instr_abort)
    else $error("abort on masked");
  AST_STALL: assert property (report.valid && |(report.exc & control_masks) |=> fixup_stall)
    else $error("no stall");
  AST_STICKY: assert property (!ops |=> &(status_flags | ~$past(status_flags)))
    else $error("flag lost");
  AST_FPU_ERROR_OUT: assert property (unm && !native_error_mode_bit |=> fpu_error_out)
    else $error("no error out");
  AST_NOWAIT: assert property (nw |=> !core_frozen)
    else $error("nowait froze");
  AST_NATIVE: assert property (native_error_mode_bit [*2] |-> !fpu_error_out)
    else $error("error out in native mode");
endmodule

bind fpuex_unit fpuex_checker chk (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .report(report),
  .ctl(ctl),
  .wait_or_float_req(wait_or_float_req),
  .next_is_nowait(next_is_nowait),
  .native_error_mode_bit(native_error_mode_bit),
  .status_flags(status_flags),
  .control_masks(control_masks),
  .fixup_stall(fixup_stall),
  .instr_abort(instr_abort),
  .core_frozen(core_frozen),
  .fpu_error_out(fpu_error_out)
);

// >>> fpuex_pic_model.sv
module fpuex_pic_model (
  // pins
  input wire logic ref_clk,
  input wire logic fpu_error_out,
  output logic maskable_interrupt_request_in,
  // line enable and handler port write
  input wire logic irq_enable,
  input wire logic port_clear
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req_q = 1'b0;
  logic fpu_error_out_q = 1'b0;
  // edge latched, so a request survives while the line is disabled
  always_ff @(posedge ref_clk) begin
    fpu_error_out_q <= fpu_error_out;
    if (port_clear) begin
      req_q <= 1'b0;
    end else if (fpu_error_out && !fpu_error_out_q) begin
      req_q <= 1'b1;
    end
  end
  assign maskable_interrupt_request_in = req_q && irq_enable;
endmodule

// >>> fpu_exception_reporting_bench.sv
module fpu_exception_reporting_bench import fpuex_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, resetn = 1'b0, wait_or_float_req = 1'b0, next_is_nowait = 1'b0;
  logic native_error_mode_bit = 1'b0, ignore_numeric_error_in = 1'b0;
  logic irq_enable = 1'b0, port_clear = 1'b0, maskable_interrupt_request_in;
  logic fixup_stall, instr_abort, handler_branch, core_frozen, fpu_error_out, coproc_error_status;
  fpuex_report_s report = '0;
  fpuex_ctl_s ctl = '0;
  fpuex_vec_t status_flags, control_masks;
  fpuex_round_e round_mode;
  fpuex_fix_e fixup_kind;
  int fails = 0, comparisons = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  fpuex_unit #(.FIXUP_CNT(2)) dut (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .report(report),
    .ctl(ctl),
    .wait_or_float_req(wait_or_float_req),
    .next_is_nowait(next_is_nowait),
    .native_error_mode_bit(native_error_mode_bit),
    .ignore_numeric_error_in(ignore_numeric_error_in),
    .maskable_interrupt_request_in(maskable_interrupt_request_in),
    .status_flags(status_flags),
    .control_masks(control_masks),
    .round_mode(round_mode),
    .fixup_kind(fixup_kind),
    .fixup_stall(fixup_stall),
    .instr_abort(instr_abort),
    .handler_branch(handler_branch),
    .core_frozen(core_frozen),
    .fpu_error_out(fpu_error_out),
    .coproc_error_status(coproc_error_status)
  );
  fpuex_pic_model pic (
    .ref_clk(ref_clk),
    .fpu_error_out(fpu_error_out),
    .maskable_interrupt_request_in(maskable_interrupt_request_in),
    .irq_enable(irq_enable),
    .port_clear(port_clear)
  );
  function automatic fpuex_report_s rep(fpuex_vec_t e, logic b);
    return '{1'b1, e, b, 1'b0};
  endfunction
  function automatic fpuex_ctl_s op(logic c, fpuex_vec_t m, logic [1:0] r);
    return '{c, 1'b0, 1'b0, 1'b0, 6'h00, !c, m, r};
  endfunction
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(fpuex_report_s r, fpuex_ctl_s c);
    @(posedge ref_clk);
    report <= r;
    ctl <= c;
    @(posedge ref_clk);
    report <= '0;
    ctl <= '0;
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // far above the fewer than a hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    tick();
    chk("reset", {status_flags, round_mode}, 8'h00);
    chk("masks", control_masks, 8'h3F);
    pulse(rep(6'h14, 1'b1), '0);
    chk("flags", status_flags, 8'h14);
    chk("fix", fixup_kind, FIX_ZERO);
    chk("quiet", {fixup_stall, instr_abort, fpu_error_out}, 8'h04);
    pulse(rep(6'h10, 1'b0), '0);
    chk("fix", fixup_kind, FIX_DENORMAL);
    pulse(rep(6'h02, 1'b0), '0);
    chk("fix", fixup_kind, FIX_INFINITY);
    pulse(rep(6'h20, 1'b0), '0);
    chk("fix", fixup_kind, FIX_ROUNDED);
    chk("sticky", status_flags, 8'h36);
    for (int i = 0; i < 4; i++) begin
      pulse('0, op(1'b0, 6'h3F, i[1:0]));
      chk("round", round_mode, i[7:0]);
    end
    $display("test masked done");
    pulse('0, op(1'b1, 6'h00, 2'h0));
    chk("clear", status_flags, 8'h00);
    pulse('0, op(1'b0, 6'h00, 2'h0));
    pulse(rep(6'h02, 1'b0), '0);
    chk("report", {instr_abort, fpu_error_out}, 8'h03);
    tick();
    chk("cerr", coproc_error_status, 8'h01);
    @(posedge ref_clk);
    wait_or_float_req <= 1'b1;
    next_is_nowait <= 1'b1;
    repeat (4) @(posedge ref_clk);
    next_is_nowait <= 1'b0;
    #1;
    chk("nowait", core_frozen, 8'h00);
    repeat (12) tick();
    chk("frozen", core_frozen, 8'h01);
    @(posedge ref_clk);
    irq_enable <= 1'b1;
    for (int k = 0; k < 10 && handler_branch !== 1'b1; k++) tick();
    chk("branch", {handler_branch, core_frozen}, 8'h02);
    @(posedge ref_clk);
    wait_or_float_req <= 1'b0;
    irq_enable <= 1'b0;
    port_clear <= 1'b1;
    @(posedge ref_clk);
    port_clear <= 1'b0;
    pulse('0, op(1'b1, 6'h00, 2'h0));
    tick();
    chk("fpu_error_out off", {fpu_error_out, coproc_error_status}, 8'h00);
    $display("test unmasked done");
    pulse(rep(6'h01, 1'b0), '0);
    @(posedge ref_clk);
    ignore_numeric_error_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wait_or_float_req <= 1'b1;
    repeat (6) tick();
    chk("ignore", core_frozen, 8'h00);
    @(posedge ref_clk);
    wait_or_float_req <= 1'b0;
    ignore_numeric_error_in <= 1'b0;
    native_error_mode_bit <= 1'b1;
    pulse('0, op(1'b1, 6'h00, 2'h0));
    pulse(rep(6'h08, 1'b0), '0);
    chk("native", {instr_abort, fpu_error_out}, 8'h02);
    @(posedge ref_clk);
    wait_or_float_req <= 1'b1;
    @(posedge ref_clk);
    wait_or_float_req <= 1'b0;
    tick();
    chk("native branch", {handler_branch, core_frozen}, 8'h02);
    pulse('0, '{1'b0, 1'b0, 1'b0, 1'b1, 6'h21, 1'b0, 6'h00, 2'h0});
    chk("restore", status_flags, 8'h21);
    pulse('0, '{1'b0, 1'b1, 1'b0, 1'b0, 6'h00, 1'b0, 6'h00, 2'h0});
    chk("reinit", {status_flags, round_mode}, 8'h00);
    chk("reinit masks", control_masks, 8'h3F);
    pulse(rep(6'h01, 1'b0), op(1'b1, 6'h00, 2'h0));
    chk("set wins", status_flags, 8'h01);
    chk("fix", fixup_kind, FIX_QNAN);
    $display("test modes done");
    summarize();
  end
endmodule
